// ---- hpia_map.svh ----
// Constants for the byte-wide host port: port addresses, control-word indices,
// reset values, field positions and core timing.
// Assumes inclusion by bare name from the package only.
`ifndef HPIA_MAP_SVH
`define HPIA_MAP_SVH

`define HPIA_PA_LANE_LAST    3'h3
`define HPIA_PA_COMMIT       3'h4
`define HPIA_PA_RB_INDEX     3'h5
`define HPIA_PA_MEM_ADDR     3'h6
`define HPIA_PA_BYTE_STEP    3'h7

`define HPIA_CW_MEM_CTRL     5'h00
`define HPIA_CW_DEV_CFG      5'h01
`define HPIA_CW_FIFO_IO      5'h02
`define HPIA_CW_UP_THR       5'h03
`define HPIA_CW_LO_THR       5'h04
`define HPIA_CW_GAIN_PHASE   5'h05
`define HPIA_CW_LOOP_FILT    5'h06
`define HPIA_CW_LOCK_PLL     5'h07
`define HPIA_CW_EVT_STATUS   5'h08
`define HPIA_CW_EVT_ENABLE   5'h09
`define HPIA_CW_CARRIER      5'h0a
`define HPIA_CW_SYMBOL       5'h0b
`define HPIA_CW_LF_UPPER     5'h0c
`define HPIA_CW_LF_LOWER     5'h0d
`define HPIA_CW_FIFO_RST     5'h0e
`define HPIA_CW_MEM_LOAD     5'h0f
`define HPIA_CW_SOFT_RST     5'h10
`define HPIA_CW_PRELOAD      5'h11
`define HPIA_CW_FIFO_WR      5'h12

`define HPIA_RST_MEM_CTRL    32'h0000_0000
`define HPIA_RST_DEV_CFG     32'h0000_602b
`define HPIA_RST_FIFO_IO     32'h0000_0000
`define HPIA_RST_UP_THR      32'hff00_0002
`define HPIA_RST_LO_THR      32'h0000_0002
`define HPIA_RST_GAIN_PHASE  32'h002f_ffff
`define HPIA_RST_LOOP_FILT   32'h5000_0000
`define HPIA_RST_LOCK_PLL    32'h0040_0000
`define HPIA_RST_LF_UPPER    32'h07ff_ffff
`define HPIA_RST_LF_LOWER    32'h8000_0000

`define HPIA_MEM_CTRL_BITS   8
`define HPIA_EVT_BITS        8
`define HPIA_PRELOAD_BITS    19

`define HPIA_SEL_NONE        3'h0
`define HPIA_SEL_I           3'h1
`define HPIA_SEL_Q           3'h2
`define HPIA_SEL_IQ          3'h3
`define HPIA_SEL_CONST       3'h4
`define HPIA_SEL_FIFO        3'h5

`define HPIA_WSEL_LAST       2'h2
`define HPIA_BYTES_COEFF     4'h9
`define HPIA_BYTES_CONST     4'h1
`define HPIA_BYTES_FIFO      4'h4

`define HPIA_CORE_PERIOD_NS  8
`define HPIA_COMMIT_GAP_CYC  4

`endif

// ---- hpia_pkg.sv ----
// Types for the byte-wide host port block.
// Assumes the constant header is on the include path.
`default_nettype none
package hpia_pkg;
  `include "hpia_map.svh"

  typedef enum logic [2:0] {
    HPIA_MEM_NONE  = 3'h0,
    HPIA_MEM_I     = 3'h1,
    HPIA_MEM_Q     = 3'h2,
    HPIA_MEM_IQ    = 3'h3,
    HPIA_MEM_CONST = 3'h4,
    HPIA_MEM_FIFO  = 3'h5,
    HPIA_MEM_RSV6  = 3'h6,
    HPIA_MEM_RSV7  = 3'h7
  } hpia_mem_sel_t;

  // Memory access control word, low byte of control word 0.
  typedef struct packed {
    logic          unused7;
    logic          auto_inc;
    logic          read_dir;
    hpia_mem_sel_t mem_sel;
    logic [1:0]    word_sel;
  } hpia_mem_ctrl_t;

  // Device configuration fields covered by this block.
  typedef struct packed {
    logic [15:0] sym_max_count;
    logic        sym_count_en;
    logic        fast_dac_delay;
    logic        bypass_final_interp;
    logic [12:0] rest;
  } hpia_dev_cfg_t;

  // One captured host write as seen in the core domain.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } hpia_wr_t;

  // Core strobes raised by commits to strobe indices.
  typedef struct packed {
    logic fifo_reset;
    logic mem_load;
    logic soft_reset;
    logic fifo_write;
  } hpia_pulse_t;

  typedef enum logic [2:0] {
    HPIA_SY_IDLE = 3'b001,
    HPIA_SY_FIRE = 3'b010,
    HPIA_SY_WAIT = 3'b100
  } hpia_sync_st_t;
endpackage : hpia_pkg
`default_nettype wire

// ---- hpia_host_port.sv ----
// Byte-wide host port: staging register, indexed control words, byte
// readback, indirect loading of coefficient and constellation memories and
// readback of those and of the FIFO memory. Host pins are sampled on sys_clk, except that rd_n and chip_sel_n drive host_data_oe_n directly; the
// write strobe is edge-detected through a two-stage synchroniser.
`default_nettype none
module hpia_host_port
  import hpia_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Host pins
  input  wire logic [2:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe_n,
  input  wire logic        chip_sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  // Core strobes and configuration
  output hpia_pulse_t      core_pulse,
  output hpia_mem_ctrl_t   mem_ctrl,
  output hpia_dev_cfg_t    dev_cfg,
  output logic      [7:0]  mem_target_address,
  // FIFO memory content supplied by the datapath for readback
  output logic      [7:0]  fifo_rd_addr,
  input  wire logic [31:0] fifo_rd_data
);

  // Write capture and strobe synchroniser.
  logic [1:0]     wr_sync_q;
  logic           wr_seen_q;
  hpia_wr_t       wr_cap_q;
  logic           wr_evt;
  hpia_sync_st_t  sy_q;
  hpia_sync_st_t  sy_d;

  logic [31:0]    staging_register_q;
  logic [31:0]    cw_q [0:31];
  logic [4:0]     readback_index_q;
  logic [7:0]     readback_mem_address_q;
  logic [3:0]     readback_byte_counter_q;
  logic [71:0]    memory_word_buffer_q;
  logic [1:0]     word_sel_q;
  logic [7:0]     auto_addr_q;
  logic [71:0]    i_coeff_ram [0:63];
  logic [71:0]    q_coeff_ram [0:63];
  logic [7:0]     const_ram [0:255];
  hpia_pulse_t    pulse_q;
  logic [7:0]     rd_byte_q;
  logic           commit_evt;
  logic [4:0]     commit_idx;
  logic [7:0]     load_addr;
  logic           load_evt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_sync_q <= 2'h3;
    end else begin
      wr_sync_q <= {wr_sync_q[0], wr_n};
    end
  end

  // Address and data are caught while the strobe is low and chip select is
  // active, so they are stable by the time the synchronised rising edge fires.
  // ignore unselected access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cap_q  <= '0;
      wr_seen_q <= 1'b0;
    end else if (!wr_n && !chip_sel_n && rd_n) begin
      wr_cap_q  <= '{addr: host_addr, data: host_data_in};
      wr_seen_q <= 1'b1;
    end else if (sy_q == HPIA_SY_FIRE) begin
      wr_seen_q <= 1'b0;
    end
  end

  always_comb begin
    sy_d   = sy_q;
    wr_evt = 1'b0;
    unique case (sy_q)
      HPIA_SY_IDLE: begin
        if (!wr_sync_q[1]) begin
          sy_d = HPIA_SY_WAIT;
        end
      end
      HPIA_SY_WAIT: begin
        if (wr_sync_q[1]) begin
          sy_d = HPIA_SY_FIRE;
        end
      end
      HPIA_SY_FIRE: begin
        wr_evt = wr_seen_q;
        sy_d   = HPIA_SY_IDLE;
      end
      default: begin
        sy_d = HPIA_SY_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_q <= HPIA_SY_IDLE;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign commit_evt = wr_evt && (wr_cap_q.addr == `HPIA_PA_COMMIT);
  assign commit_idx = wr_cap_q.data[4:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      staging_register_q <= '0;
    end else if (wr_evt && wr_cap_q.addr <= `HPIA_PA_LANE_LAST) begin
      staging_register_q[wr_cap_q.addr[1:0]*8 +: 8] <= wr_cap_q.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 32; k++) begin
        cw_q[k] <= '0;
      end
      cw_q[`HPIA_CW_MEM_CTRL]   <= `HPIA_RST_MEM_CTRL;
      cw_q[`HPIA_CW_DEV_CFG]    <= `HPIA_RST_DEV_CFG;
      cw_q[`HPIA_CW_FIFO_IO]    <= `HPIA_RST_FIFO_IO;
      cw_q[`HPIA_CW_UP_THR]     <= `HPIA_RST_UP_THR;
      cw_q[`HPIA_CW_LO_THR]     <= `HPIA_RST_LO_THR;
      cw_q[`HPIA_CW_GAIN_PHASE] <= `HPIA_RST_GAIN_PHASE;
      cw_q[`HPIA_CW_LOOP_FILT]  <= `HPIA_RST_LOOP_FILT;
      cw_q[`HPIA_CW_LOCK_PLL]   <= `HPIA_RST_LOCK_PLL;
      cw_q[`HPIA_CW_LF_UPPER]   <= `HPIA_RST_LF_UPPER;
      cw_q[`HPIA_CW_LF_LOWER]   <= `HPIA_RST_LF_LOWER;
    end else if (commit_evt) begin
      unique case (commit_idx)
        `HPIA_CW_FIFO_RST, `HPIA_CW_MEM_LOAD, `HPIA_CW_SOFT_RST, `HPIA_CW_FIFO_WR,
        `HPIA_CW_EVT_STATUS: begin
        end
        `HPIA_CW_MEM_CTRL, `HPIA_CW_EVT_ENABLE: begin
          cw_q[commit_idx] <= {24'h0, staging_register_q[`HPIA_MEM_CTRL_BITS-1:0]};
        end
        `HPIA_CW_PRELOAD: begin
          cw_q[commit_idx] <= {13'h0, staging_register_q[`HPIA_PRELOAD_BITS-1:0]};
        end
        default: begin
          cw_q[commit_idx] <= staging_register_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q.fifo_reset <= commit_evt && commit_idx == `HPIA_CW_FIFO_RST;
      pulse_q.mem_load   <= commit_evt && commit_idx == `HPIA_CW_MEM_LOAD;
      pulse_q.soft_reset <= commit_evt && commit_idx == `HPIA_CW_SOFT_RST;
      pulse_q.fifo_write <= commit_evt && commit_idx == `HPIA_CW_FIFO_WR;
    end
  end
  assign core_pulse = pulse_q;

  assign mem_ctrl = hpia_mem_ctrl_t'(cw_q[`HPIA_CW_MEM_CTRL][`HPIA_MEM_CTRL_BITS-1:0]);
  assign dev_cfg  = hpia_dev_cfg_t'(cw_q[`HPIA_CW_DEV_CFG]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      readback_index_q        <= '0;
      readback_mem_address_q  <= '0;
      readback_byte_counter_q <= '0;
    end else if (wr_evt) begin
      if (wr_cap_q.addr == `HPIA_PA_RB_INDEX) begin
        readback_index_q <= wr_cap_q.data[4:0];
      end
      if (wr_cap_q.addr == `HPIA_PA_MEM_ADDR) begin
        readback_mem_address_q  <= wr_cap_q.data;
        readback_byte_counter_q <= '0;
      end
      if (wr_cap_q.addr == `HPIA_PA_BYTE_STEP) begin
        readback_byte_counter_q <= readback_byte_counter_q + 4'h1;
      end
    end
  end

  // The load acts in the same cycle as the commit, one cycle ahead of the
  // exported strobe, so the buffer and memories are settled when it shows.
  assign load_evt  = commit_evt && commit_idx == `HPIA_CW_MEM_LOAD &&
                     !mem_ctrl.read_dir;
  // Writing control word 0 restarts the internal auto address at zero.
  // entry address from lane 3
  assign load_addr = mem_ctrl.auto_inc ? auto_addr_q : staging_register_q[31:24];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_word_buffer_q <= '0;
      word_sel_q           <= '0;
      auto_addr_q          <= '0;
      mem_target_address   <= '0;
    end else if (commit_evt && commit_idx == `HPIA_CW_MEM_CTRL) begin
      word_sel_q  <= staging_register_q[1:0];
      auto_addr_q <= '0;
    end else if (load_evt) begin
      mem_target_address <= load_addr;
      if (mem_ctrl.mem_sel == HPIA_MEM_CONST) begin
        memory_word_buffer_q[71:64] <= staging_register_q[23:16];
        if (mem_ctrl.auto_inc) begin
          auto_addr_q <= auto_addr_q + 8'h1;
        end
      end else begin
        memory_word_buffer_q[word_sel_q*24 +: 24] <= staging_register_q[23:0];
        if (word_sel_q == `HPIA_WSEL_LAST) begin
          word_sel_q <= '0;
          if (mem_ctrl.auto_inc) begin
            auto_addr_q <= auto_addr_q + 8'h1;
          end
        end else begin
          word_sel_q <= word_sel_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (load_evt && word_sel_q == `HPIA_WSEL_LAST) begin
      if (mem_ctrl.mem_sel == HPIA_MEM_I || mem_ctrl.mem_sel == HPIA_MEM_IQ) begin
        i_coeff_ram[load_addr[5:0]] <= {staging_register_q[23:0], memory_word_buffer_q[47:0]};
      end
      if (mem_ctrl.mem_sel == HPIA_MEM_Q || mem_ctrl.mem_sel == HPIA_MEM_IQ) begin
        q_coeff_ram[load_addr[5:0]] <= {staging_register_q[23:0], memory_word_buffer_q[47:0]};
      end
    end
    if (load_evt && word_sel_q == 2'h0 && mem_ctrl.mem_sel == HPIA_MEM_CONST) begin
      const_ram[load_addr] <= staging_register_q[23:16];
    end
  end

  assign fifo_rd_addr = readback_mem_address_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_q <= '0;
    end else if (!host_addr[2]) begin
      rd_byte_q <= cw_q[readback_index_q][host_addr[1:0]*8 +: 8];
    end else begin
      unique case (mem_ctrl.mem_sel)
        HPIA_MEM_I, HPIA_MEM_IQ: begin
          rd_byte_q <= (readback_byte_counter_q < `HPIA_BYTES_COEFF) ?
            i_coeff_ram[readback_mem_address_q[5:0]][readback_byte_counter_q*8 +: 8] : 8'h00;
        end
        HPIA_MEM_Q: begin
          rd_byte_q <= (readback_byte_counter_q < `HPIA_BYTES_COEFF) ?
            q_coeff_ram[readback_mem_address_q[5:0]][readback_byte_counter_q*8 +: 8] : 8'h00;
        end
        HPIA_MEM_CONST: begin
          rd_byte_q <= (readback_byte_counter_q < `HPIA_BYTES_CONST) ?
            const_ram[readback_mem_address_q] : 8'h00;
        end
        HPIA_MEM_FIFO: begin
          rd_byte_q <= (readback_byte_counter_q < `HPIA_BYTES_FIFO) ?
            fifo_rd_data[readback_byte_counter_q[1:0]*8 +: 8] : 8'h00;
        end
        default: begin
          rd_byte_q <= 8'h00;
        end
      endcase
    end
  end

  assign host_data_out  = rd_byte_q;
  assign host_data_oe_n = rd_n | chip_sel_n;

endmodule : hpia_host_port
`default_nettype wire

// ---- hpia_host_bfm.sv ----
// Host processor model driving the byte-wide port pins.
// Assumes the device samples its pins on the rising edge of sys_clk.
`default_nettype none
module hpia_host_bfm (
  // Clock
  input  wire logic       sys_clk,
  // Host pins
  output var logic [2:0]  host_addr,
  output var logic [7:0]  host_data_in,
  output var logic        chip_sel_n,
  output var logic        rd_n,
  output var logic        wr_n,
  input  wire logic [7:0] host_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_addr = 3'h0;
    host_data_in = 8'h00;
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic cs_n);
    @(negedge sys_clk);
    host_addr = a;
    host_data_in = d;
    chip_sel_n = cs_n;
    wr_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    wr_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chip_sel_n = 1'b1;
    // A released bus must not keep showing the old byte.
    host_data_in = ~d;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    host_addr = a;
    chip_sel_n = 1'b0;
    rd_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    d = host_data_out;
    rd_n = 1'b1;
    chip_sel_n = 1'b1;
  endtask : rd
endmodule : hpia_host_bfm
`default_nettype wire

// ---- hpia_host_port_chk.sv ----
// Assertions on the host port's top-level pins.
// Assumes one clock domain; bound into every host port instance below.
`default_nettype none
module hpia_chk
  import hpia_pkg::*;
(
  // Clock and reset
  input wire logic           sys_clk,
  input wire logic           rst_n,
  // Host pins
  input wire logic [2:0]     host_addr,
  input wire logic [7:0]     host_data_out,
  input wire logic           host_data_oe_n,
  input wire logic           chip_sel_n,
  input wire logic           rd_n,
  input wire logic           wr_n,
  // Core side
  input wire hpia_pulse_t    core_pulse,
  input wire hpia_mem_ctrl_t mem_ctrl,
  input wire hpia_dev_cfg_t  dev_cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Cycles since a selected write strobe, saturating at fifteen.
  logic [3:0] wr_age_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      wr_age_q <= 4'hf;
    else if (!wr_n && !chip_sel_n && rd_n)
      wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf)
      wr_age_q <= wr_age_q + 4'h1;
  end

  oe_follows_a: assert property (host_data_oe_n == (rd_n | chip_sel_n))
    else $error("bus enable does not follow read and select");
  pulse_single_a: assert property (core_pulse != 4'h0 |=> core_pulse == 4'h0)
    else $error("core pulse longer than one cycle");
  pulse_onehot_a: assert property ($onehot0(core_pulse))
    else $error("two core pulses at once");
  pulse_cause_a: assert property (core_pulse != 4'h0 |-> wr_age_q inside {[4'h1:4'h9]})
    else $error("core pulse without a recent write");
  cfg_cause_a: assert property (!$stable(dev_cfg) |-> wr_age_q <= 4'h9)
    else $error("configuration changed without a write");
  ctrl_cause_a: assert property (!$stable(mem_ctrl) |-> wr_age_q <= 4'h9)
    else $error("memory control changed without a write");
  reset_value_a: assert property ($rose(rst_n) |-> dev_cfg == 32'h0000_602b && mem_ctrl == 8'h00)
    else $error("control words not at reset values");
  none_reads_zero_a: assert property ((!rd_n && !chip_sel_n && host_addr[2]
      && mem_ctrl.mem_sel == HPIA_MEM_NONE) [*2] |-> host_data_out == 8'h00)
    else $error("memory read with no access selected not zero");
endmodule : hpia_chk

bind hpia_host_port hpia_chk chk_u (.sys_clk, .rst_n, .host_addr, .host_data_out,
  .host_data_oe_n, .chip_sel_n, .rd_n, .wr_n, .core_pulse, .mem_ctrl, .dev_cfg);
`default_nettype wire

// ---- host_port_indirect_access_bench.sv ----
// Self-checking bench: control words, memory load and readback, strobes.
// Assumes the host model module and the bound checker are compiled too.
`default_nettype none
module host_port_indirect_access_bench
  import hpia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [2:0]     host_addr;
  logic [7:0]     host_data_in;
  logic [7:0]     host_data_out;
  logic           host_data_oe_n;
  logic           chip_sel_n;
  logic           rd_n;
  logic           wr_n;
  hpia_pulse_t    core_pulse;
  hpia_mem_ctrl_t mem_ctrl;
  hpia_dev_cfg_t  dev_cfg;
  logic [7:0]     mem_target_address;
  logic [7:0]     fifo_rd_addr;
  logic [31:0]    fifo_rd_data;
  logic [7:0]     b;
  int             fails = 0;
  int             samples_checked = 0;
  int             pc[4] = '{0, 0, 0, 0};
  logic [31:0]    rst_tab[20] = '{0, 32'h602b, 0, 32'hff000002, 2, 32'h2fffff,
    32'h50000000, 32'h400000, 0, 0, 0, 0, 32'h7ffffff, 32'h80000000, 0, 0, 0, 0, 0, 0};
  logic [71:0]    coef = 72'h99_8877_6655_4433_2211;

  always #4 sys_clk = ~sys_clk;
  // The datapath's FIFO word depends on its address, so a wrong address shows.
  assign fifo_rd_data = {fifo_rd_addr, ~fifo_rd_addr, 8'h3c, 8'h96};

  // Pulses launch on the rising edge, so count them where they are settled.
  always @(negedge sys_clk)
    for (int i = 0; i < 4; i++)
      if (core_pulse[i] === 1'b1) pc[i]++;

  hpia_host_port dut_u (.sys_clk, .rst_n, .host_addr, .host_data_in, .host_data_out,
    .host_data_oe_n, .chip_sel_n, .rd_n, .wr_n, .core_pulse, .mem_ctrl, .dev_cfg,
    .mem_target_address, .fifo_rd_addr, .fifo_rd_data);
  hpia_host_bfm bfm_u (.sys_clk, .host_addr, .host_data_in, .chip_sel_n, .rd_n, .wr_n,
    .host_data_out);

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk32

  task automatic cw_wr(input logic [4:0] idx, input logic [31:0] v, input logic cs_n);
    for (int i = 0; i < 4; i++)
      bfm_u.wr(3'(i), v[8*i+:8], cs_n);
    bfm_u.wr(3'h4, {3'h0, idx}, cs_n);
  endtask : cw_wr

  task automatic cw_chk(input logic [4:0] idx, input logic [31:0] e);
    bfm_u.wr(3'h5, {3'h0, idx}, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bfm_u.rd(3'(i), b);
      chk8("control word byte", e[8*i+:8], b);
    end
  endtask : cw_chk

  task automatic mem_chk(input logic [7:0] a, input int n, input logic [79:0] e);
    bfm_u.wr(3'h6, a, 1'b0);
    for (int i = 0; i < n; i++) begin
      bfm_u.rd(3'(4 + i % 4), b);
      chk8("memory byte", e[8*i+:8], b);
      bfm_u.wr(3'h7, 8'h00, 1'b0);
    end
  endtask : mem_chk

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk32("configuration port", 32'h0000602b, dev_cfg);
    for (int k = 0; k < 20; k++)
      if (!(k inside {14, 15, 16, 18})) cw_chk(5'(k), rst_tab[k]);
    bfm_u.rd(3'h4, b);
    chk8("read with no memory", 8'h00, b);
    cw_wr(5'h0c, 32'haabbccdd, 1'b0);
    cw_chk(5'h0c, 32'haabbccdd);
    cw_wr(5'h0c, 32'h11223344, 1'b1);
    cw_chk(5'h0c, 32'haabbccdd);
    cw_wr(5'h08, 32'h5a5a5a5a, 1'b0);
    cw_chk(5'h08, 32'h0);
    cw_wr(5'h01, 32'hbeef8000, 1'b0);
    chk32("configuration port", 32'hbeef8000, dev_cfg);
    cw_wr(5'h00, 32'h10, 1'b0);
    bfm_u.wr(3'h2, 8'h5a, 1'b0);
    bfm_u.wr(3'h3, 8'h21, 1'b0);
    bfm_u.wr(3'h4, 8'h0f, 1'b0);
    chk8("target address", 8'h21, mem_target_address);
    cw_wr(5'h00, 32'h30, 1'b0);
    chk8("memory control", 8'h30, mem_ctrl);
    mem_chk(8'h21, 2, 80'h5a);
    cw_wr(5'h00, 32'h04, 1'b0);
    for (int j = 0; j < 3; j++)
      cw_wr(5'h0f, {8'h12, coef[24*j+:24]}, 1'b0);
    cw_wr(5'h00, 32'h24, 1'b0);
    mem_chk(8'h12, 10, {8'h00, coef});
    mem_chk(8'h12, 1, {8'h00, coef});
    cw_wr(5'h00, 32'h34, 1'b0);
    mem_chk(8'h40, 5, 80'h40bf3c96);
    chk8("fifo address", 8'h40, fifo_rd_addr);
    cw_wr(5'h00, 32'h00, 1'b0);
    bfm_u.wr(3'h4, 8'h0e, 1'b0);
    bfm_u.wr(3'h4, 8'h12, 1'b0);
    bfm_u.wr(3'h4, 8'h10, 1'b0);
    chk32("fifo reset pulses", 32'd1, 32'(pc[3]));
    chk32("load pulses", 32'd4, 32'(pc[2]));
    chk32("soft reset pulses", 32'd1, 32'(pc[1]));
    chk32("fifo write pulses", 32'd1, 32'(pc[0]));
    end_of_test();
  end
endmodule : host_port_indirect_access_bench
`default_nettype wire
